// [gis_global_status.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Global interrupt status
// ----------------------------------------
// Overview of operation
// - Pending byte bit 0 flags channel 0, bit 1 channel 1, rest zero.
// - Pending bit rises on any rx, tx, line or modem request of channel.
// - Pending bit drops once host read clears the channel's underlying source.
// - Three-bit source code: channel 0 in bits 10:8, channel 1 in 13:11.
// - Wake-up, timer and multipin sources show only in channel 0 code.
// - Code 000 means nothing pending, or wake-up on channel 0.
// - Code 001 is rx ready or line status; code 010 rx time-out.
// - Line status condition is the OR of line status bits 4 to 1.
// - Code 011 is transmit ready; code 100 modem, flow or character events.
// - Code 101 unused; 110 multipin, 111 timer, channel 0 only.
// - Several sources pending: report the best priority, 1 highest.
// - Wake-up raised on leaving sleep only if both channels had slept.
// - Reading the pending byte clears the wake-up indication.
// - Whole status word is zero after reset.
// - Rx ready and rx time-out clear when the receive data is read.
// - Line status source clears after reading the line status register.
// - Transmit ready clears after reading the channel irq status register.
// - Modem and flow-line sources clear after reading modem status register.
// - Xon/Xoff and special character clear after irq status register read.
// - Timer source clears after reading the timer command register.
// - Multipin source clears after reading the multipin level register.
// - Pending byte and both codes form one word at 0x0080.

module gis_global_status (
  input  wire  logic            CLK_IN,
  input  wire  logic            RST_N_IN,
  // Register access, dword address plus byte lanes
  input  wire  logic            REG_RD_IN,
  input  wire  logic            REG_WR_IN,
  input  wire  logic [10:2]     REG_ADDR_IN,
  input  wire  logic [3:0]      REG_BE_IN,
  output logic       [31:0]     REG_RDATA_OUT,
  output logic                  REG_RVALID_OUT,
  // Per-channel requests from the UART logic
  input  wire  logic [1:0]      RX_DATA_READY_IN,
  input  wire  logic [1:0][7:0] LINE_STATUS_IN,
  input  wire  logic [1:0]      RX_TIMEOUT_IN,
  input  wire  logic [1:0]      TX_SPACE_READY_IN,
  input  wire  logic [1:0]      MODEM_DELTA_IN,
  input  wire  logic [1:0]      XON_XOFF_DET_IN,
  input  wire  logic [1:0]      SPECIAL_CHAR_IN,
  // Device-wide requests
  input  wire  logic            TIMER_IRQ_IN,
  input  wire  logic            MULTIPIN_IRQ_IN,
  input  wire  logic [1:0]      CH_SLEEP_IN,
  // Status and read-clear strobes
  output logic       [31:0]     GLOBAL_STATUS_OUT,
  output logic                  WAKE_PENDING_OUT,
  output logic       [1:0]      CH_RX_READ_OUT,
  output logic       [1:0]      CH_LSR_READ_OUT,
  output logic       [1:0]      CH_ISR_READ_OUT,
  output logic       [1:0]      CH_MSR_READ_OUT,
  output logic                  TIMER_CMD_READ_OUT,
  output logic                  MULTIPIN_LEVEL_READ_OUT
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] rdata;
    logic        rvalid;
    logic        wake;
    logic        both_asleep;
    logic [1:0]  rx_rd;
    logic [1:0]  lsr_rd;
    logic [1:0]  isr_rd;
    logic [1:0]  msr_rd;
    logic        timer_rd;
    logic        mpin_rd;
  } gis_state_t;

  localparam gis_state_t STATE_RESET = '{
    status:      gis_pkg::STATUS_RESET,
    rdata:       32'h0000_0000,
    rvalid:      1'b0,
    wake:        1'b0,
    both_asleep: 1'b0,
    rx_rd:       2'h0,
    lsr_rd:      2'h0,
    isr_rd:      2'h0,
    msr_rd:      2'h0,
    timer_rd:    1'b0,
    mpin_rd:     1'b0
  };

  gis_state_t st_q;
  gis_state_t st_d;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Byte read at a given byte offset within the dword access
  function automatic logic byte_rd(input logic [10:2] a,
                                   input logic [3:0]  be,
                                   input logic [10:0] ofs);
    byte_rd = (a == ofs[10:2]) && be[ofs[1:0]];
  endfunction

  // Configuration space is seen from both channel halves
  function automatic logic cfg_rd(input logic [10:2] a,
                                  input logic [3:0]  be,
                                  input logic [10:0] ofs);
    cfg_rd = byte_rd(a, be, ofs) | byte_rd(a, be, ofs | gis_pkg::CH1_BASE);
  endfunction

  // Channel register read, channel selected by the base
  function automatic logic ch_rd(input logic [10:2] a,
                                 input logic [3:0]  be,
                                 input logic        ch,
                                 input logic [10:0] ofs);
    logic [10:0] base;
    base  = ch ? gis_pkg::CH1_BASE : 11'h000;
    ch_rd = byte_rd(a, be, base | ofs);
  endfunction

  // Receive FIFO windows, plain and with errors, above the registers
  function automatic logic fifo_rd(input logic [10:2] a,
                                   input logic        ch);
    fifo_rd = (a[10] == ch) && (a[9:8] != 2'h0);
  endfunction

  // ----------------------------------------
  // Channel encoders
  // ----------------------------------------
  gis_src_if ch0_if ();
  gis_src_if ch1_if ();

  assign ch0_if.rx_ready     = RX_DATA_READY_IN[0];
  assign ch0_if.line_err     = LINE_STATUS_IN[0][gis_pkg::LSR_ERR_HI:gis_pkg::LSR_ERR_LO];
  assign ch0_if.rx_timeout   = RX_TIMEOUT_IN[0];
  assign ch0_if.tx_ready     = TX_SPACE_READY_IN[0];
  assign ch0_if.modem_delta  = MODEM_DELTA_IN[0];
  assign ch0_if.xon_xoff     = XON_XOFF_DET_IN[0];
  assign ch0_if.special_char = SPECIAL_CHAR_IN[0];
  assign ch0_if.mpin_irq     = MULTIPIN_IRQ_IN;
  assign ch0_if.timer_irq    = TIMER_IRQ_IN;

  assign ch1_if.rx_ready     = RX_DATA_READY_IN[1];
  assign ch1_if.line_err     = LINE_STATUS_IN[1][gis_pkg::LSR_ERR_HI:gis_pkg::LSR_ERR_LO];
  assign ch1_if.rx_timeout   = RX_TIMEOUT_IN[1];
  assign ch1_if.tx_ready     = TX_SPACE_READY_IN[1];
  assign ch1_if.modem_delta  = MODEM_DELTA_IN[1];
  assign ch1_if.xon_xoff     = XON_XOFF_DET_IN[1];
  assign ch1_if.special_char = SPECIAL_CHAR_IN[1];
  // Global sources never reach channel 1
  assign ch1_if.mpin_irq     = 1'b0;
  assign ch1_if.timer_irq    = 1'b0;

  gis_src_encoder u_enc0 (
    .s (ch0_if)
  );

  gis_src_encoder u_enc1 (
    .s (ch1_if)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic       rd;
  logic       pend_rd;
  logic       all_asleep;
  logic [1:0] rx_rd;
  logic [1:0] lsr_rd;
  logic [1:0] isr_rd;
  logic [1:0] msr_rd;

  assign rd         = REG_RD_IN;
  assign all_asleep = &CH_SLEEP_IN;
  assign pend_rd    = rd && cfg_rd(REG_ADDR_IN, REG_BE_IN, gis_pkg::STATUS_OFS);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign rx_rd[c]  = rd && (ch_rd(REG_ADDR_IN, REG_BE_IN, c[0], gis_pkg::RX_HOLD_OFS)
                             || fifo_rd(REG_ADDR_IN, c[0]));
    assign lsr_rd[c] = rd && ch_rd(REG_ADDR_IN, REG_BE_IN, c[0], gis_pkg::LINE_STAT_OFS);
    assign isr_rd[c] = rd && ch_rd(REG_ADDR_IN, REG_BE_IN, c[0], gis_pkg::IRQ_STAT_OFS);
    assign msr_rd[c] = rd && ch_rd(REG_ADDR_IN, REG_BE_IN, c[0], gis_pkg::MODEM_STAT_OFS);
  end

  always_comb begin
    st_d = st_q;

    // Word built fresh each cycle, so reserved bits stay zero
    st_d.status = 32'h0000_0000;
    st_d.status[gis_pkg::PEND_LSB]     = ch0_if.pending;
    st_d.status[gis_pkg::PEND_LSB + 1] = ch1_if.pending;
    st_d.status[gis_pkg::CODE0_LSB +: 3] = ch0_if.code;
    st_d.status[gis_pkg::CODE1_LSB +: 3] = ch1_if.code;

    // Arm on both asleep, fire on the wake that follows
    st_d.both_asleep = all_asleep;
    if (st_q.both_asleep && !all_asleep) begin
      st_d.wake = 1'b1;
    end else if (pend_rd) begin
      st_d.wake = 1'b0;
    end

    // Return the word as it stood before any clear lands
    st_d.rvalid = rd;
    if (rd) begin
      st_d.rdata = cfg_rd(REG_ADDR_IN, 4'hf, gis_pkg::STATUS_OFS) ? st_q.status
                                                                  : 32'h0000_0000;
    end
    // Writes are dropped; REG_WR_IN only holds rdata at its old value when a read comes in the same cycle
    if (REG_WR_IN) begin
      st_d.rdata = st_q.rdata;
    end

    // Read strobes that let the owners clear their sources
    st_d.rx_rd    = rx_rd;
    st_d.lsr_rd   = lsr_rd;
    st_d.isr_rd   = isr_rd;
    st_d.msr_rd   = msr_rd;
    st_d.timer_rd = rd && cfg_rd(REG_ADDR_IN, REG_BE_IN, gis_pkg::TIMER_CMD_OFS);
    st_d.mpin_rd  = rd && (cfg_rd(REG_ADDR_IN, REG_BE_IN, gis_pkg::MPIN_LVL_LO_OFS)
                          || cfg_rd(REG_ADDR_IN, REG_BE_IN, gis_pkg::MPIN_LVL_HI_OFS));
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign REG_RDATA_OUT           = st_q.rdata;
  assign REG_RVALID_OUT          = st_q.rvalid;
  assign GLOBAL_STATUS_OUT       = st_q.status;
  assign WAKE_PENDING_OUT        = st_q.wake;
  assign CH_RX_READ_OUT          = st_q.rx_rd;
  assign CH_LSR_READ_OUT         = st_q.lsr_rd;
  assign CH_ISR_READ_OUT         = st_q.isr_rd;
  assign CH_MSR_READ_OUT         = st_q.msr_rd;
  assign TIMER_CMD_READ_OUT      = st_q.timer_rd;
  assign MULTIPIN_LEVEL_READ_OUT = st_q.mpin_rd;

endmodule

`default_nettype wire

// [gis_pkg.sv]
package gis_pkg;

  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [10:0] STATUS_OFS      = 11'h080;
  localparam logic [10:0] TIMER_CMD_OFS   = 11'h084;
  localparam logic [10:0] MPIN_LVL_LO_OFS = 11'h090;
  localparam logic [10:0] MPIN_LVL_HI_OFS = 11'h096;
  localparam logic [10:0] CH1_BASE        = 11'h400;
  // Channel register offsets, 16550 layout
  localparam logic [10:0] RX_HOLD_OFS     = 11'h000;
  localparam logic [10:0] IRQ_STAT_OFS    = 11'h002;
  localparam logic [10:0] LINE_STAT_OFS   = 11'h005;
  localparam logic [10:0] MODEM_STAT_OFS  = 11'h006;

  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int          PEND_LSB        = 0;
  localparam int          CODE0_LSB       = 8;
  localparam int          CODE1_LSB       = 11;
  localparam int          LSR_ERR_HI      = 4;
  localparam int          LSR_ERR_LO      = 1;
  localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;

  // ----------------------------------------
  // Source codes, priority 1 is best
  // ----------------------------------------
  localparam logic [2:0]  CODE_NONE       = 3'h0;
  localparam logic [2:0]  CODE_RX         = 3'h1;
  localparam logic [2:0]  CODE_RX_TIMEOUT = 3'h2;
  localparam logic [2:0]  CODE_TX         = 3'h3;
  localparam logic [2:0]  CODE_MODEM      = 3'h4;
  localparam logic [2:0]  CODE_MPIN       = 3'h6;
  localparam logic [2:0]  CODE_TIMER      = 3'h7;

endpackage

// [gis_src_if.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// One channel's service requests and result
// ----------------------------------------
interface gis_src_if;
  logic       rx_ready;
  logic [3:0] line_err;
  logic       rx_timeout;
  logic       tx_ready;
  logic       modem_delta;
  logic       xon_xoff;
  logic       special_char;
  logic       mpin_irq;
  logic       timer_irq;
  logic [2:0] code;
  logic       pending;

  modport src (
    output rx_ready, line_err, rx_timeout, tx_ready, modem_delta,
           xon_xoff, special_char, mpin_irq, timer_irq,
    input  code, pending
  );
  modport enc (
    input  rx_ready, line_err, rx_timeout, tx_ready, modem_delta,
           xon_xoff, special_char, mpin_irq, timer_irq,
    output code, pending
  );
endinterface

`default_nettype wire

// [gis_src_encoder.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Priority encoder for one channel
// ----------------------------------------
module gis_src_encoder (
  gis_src_if.enc s
);
  logic rx_any;
  logic modem_any;

  assign rx_any    = s.rx_ready | (|s.line_err);
  assign modem_any = s.modem_delta | s.xon_xoff | s.special_char;
  // Device-wide sources do not mark the channel as needing service
  assign s.pending = rx_any | s.rx_timeout | s.tx_ready | modem_any;

  always_comb begin
    // Best priority first; wake-up shares the idle code
    if (rx_any) begin
      s.code = gis_pkg::CODE_RX;
    end else if (s.rx_timeout) begin
      s.code = gis_pkg::CODE_RX_TIMEOUT;
    end else if (s.tx_ready) begin
      s.code = gis_pkg::CODE_TX;
    end else if (modem_any) begin
      s.code = gis_pkg::CODE_MODEM;
    end else if (s.mpin_irq) begin
      s.code = gis_pkg::CODE_MPIN;
    end else if (s.timer_irq) begin
      s.code = gis_pkg::CODE_TIMER;
    end else begin
      s.code = gis_pkg::CODE_NONE;
    end
  end
endmodule

`default_nettype wire

// [gis_src_model.sv]
`timescale 1ns/1ns
`default_nettype none
// --------
// Channel and device sources
// --------
// Each source holds until its owner's register is read.
module gis_src_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] set_in,
  input  wire logic [1:0]  rx_rd_in,
  input  wire logic [1:0]  lsr_rd_in,
  input  wire logic [1:0]  isr_rd_in,
  input  wire logic [1:0]  msr_rd_in,
  input  wire logic        tmr_rd_in,
  input  wire logic        mpin_rd_in,
  output logic      [15:0] src_out
);
  logic [15:0] clr;
  always_comb begin
    clr[15] = mpin_rd_in;
    clr[14] = tmr_rd_in;
    for (int c = 0; c < 2; c++) begin
      clr[c*7]   = rx_rd_in[c];
      clr[c*7+1] = lsr_rd_in[c];
      clr[c*7+2] = rx_rd_in[c];
      clr[c*7+3] = isr_rd_in[c];
      clr[c*7+4] = msr_rd_in[c];
      clr[c*7+5] = isr_rd_in[c];
      clr[c*7+6] = isr_rd_in[c];
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_out <= 16'h0000;
    end else begin
      src_out <= (src_out & ~clr) | set_in;
    end
  end
endmodule
`default_nettype wire

// [gis_global_status_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module gis_global_status_checker (
  input wire logic            CLK_IN,
  input wire logic            RST_N_IN,
  input wire logic            REG_RD_IN,
  input wire logic [10:2]     REG_ADDR_IN,
  input wire logic [3:0]      REG_BE_IN,
  input wire logic [31:0]     REG_RDATA_OUT,
  input wire logic            REG_RVALID_OUT,
  input wire logic [1:0]      RX_DATA_READY_IN,
  input wire logic [1:0][7:0] LINE_STATUS_IN,
  input wire logic [1:0]      RX_TIMEOUT_IN,
  input wire logic [1:0]      TX_SPACE_READY_IN,
  input wire logic [1:0]      CH_SLEEP_IN,
  input wire logic [31:0]     GLOBAL_STATUS_OUT,
  input wire logic            WAKE_PENDING_OUT,
  input wire logic [1:0]      CH_LSR_READ_OUT,
  input wire logic            TIMER_CMD_READ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_sleep_exit;
    CH_SLEEP_IN == 2'b11 ##1 CH_SLEEP_IN != 2'b11;
  endsequence
  sequence s_status_rd;
    REG_RD_IN && REG_ADDR_IN[9:2] == 8'h20;
  endsequence
  a_rvalid_on_read: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read not answered");
  a_rdata_status: assert property (s_status_rd |=>
    REG_RDATA_OUT == $past(GLOBAL_STATUS_OUT)) else $error("read data wrong");
  a_reserved_zero: assert property (GLOBAL_STATUS_OUT[31:14] == 18'h0 &&
    GLOBAL_STATUS_OUT[7:2] == 6'h0) else $error("reserved bit set");
  a_no_code_five: assert property (GLOBAL_STATUS_OUT[10:8] != 3'h5 &&
    GLOBAL_STATUS_OUT[13:11] != 3'h5) else $error("code 5 seen");
  a_rx_best: assert property (RX_DATA_READY_IN[0] |=>
    GLOBAL_STATUS_OUT[10:8] == 3'h1 && GLOBAL_STATUS_OUT[0]) else $error("rx code");
  a_line_err_code: assert property (|LINE_STATUS_IN[1][4:1] |=>
    GLOBAL_STATUS_OUT[13:11] == 3'h1 && GLOBAL_STATUS_OUT[1]) else $error("lsr code");
  a_tx_ch1_code: assert property (TX_SPACE_READY_IN[1] && !RX_DATA_READY_IN[1] &&
    !RX_TIMEOUT_IN[1] && LINE_STATUS_IN[1][4:1] == 4'h0 |=>
    GLOBAL_STATUS_OUT[13:11] == 3'h3) else $error("tx code");
  a_wake_set: assert property (s_sleep_exit |=> WAKE_PENDING_OUT)
    else $error("wake missing");
  a_wake_clear: assert property (s_status_rd and REG_BE_IN[0] &&
    $past(CH_SLEEP_IN) != 2'b11 |=> !WAKE_PENDING_OUT) else $error("wake stuck");
  a_lsr_strobe: assert property (REG_RD_IN && REG_ADDR_IN == 9'h001 &&
    REG_BE_IN[1] |=> CH_LSR_READ_OUT[0]) else $error("lsr strobe");
  a_timer_strobe: assert property (REG_RD_IN && REG_ADDR_IN[9:2] == 8'h21 &&
    REG_BE_IN[0] |=> TIMER_CMD_READ_OUT) else $error("timer strobe");
endmodule
bind gis_global_status gis_global_status_checker chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_BE_IN(REG_BE_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .RX_DATA_READY_IN(RX_DATA_READY_IN), .LINE_STATUS_IN(LINE_STATUS_IN),
  .RX_TIMEOUT_IN(RX_TIMEOUT_IN), .TX_SPACE_READY_IN(TX_SPACE_READY_IN),
  .CH_SLEEP_IN(CH_SLEEP_IN), .GLOBAL_STATUS_OUT(GLOBAL_STATUS_OUT),
  .WAKE_PENDING_OUT(WAKE_PENDING_OUT), .CH_LSR_READ_OUT(CH_LSR_READ_OUT),
  .TIMER_CMD_READ_OUT(TIMER_CMD_READ_OUT));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct packed {
    logic [15:0] set;
    logic [7:0]  lx;
    logic [31:0] mask;
    logic [31:0] exp;
  } gis_row_t;
  typedef struct packed {
    logic [10:2] a;
    logic [3:0]  be;
    logic [15:0] set;
    logic [31:0] exp;
  } gis_rd_t;
  logic        clk_in = 1'b0;
  logic        rst_n = 1'b0;
  logic        mrst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [10:2] addr = 9'h000;
  logic [3:0]  be = 4'h0;
  logic [15:0] set = 16'h0000;
  logic [7:0]  lx = 8'h00;
  logic [1:0]  sleep = 2'h0;
  logic [15:0] src;
  logic [31:0] rdata, status, msk;
  logic        rvalid, wake, tmr_rd, mpin_rd;
  logic [1:0]  rx_rd, lsr_rd, isr_rd, msr_rd;
  int          n_fail = 0;
  int          tests_run = 0;
  // Source bits per channel: rx, line, timeout, tx, modem, xon, special
  gis_row_t rows [14] = '{
    '{16'h0400, 8'h00, 32'hffff_ffff, 32'h0000_1802},
    '{16'h0019, 8'h00, 32'hffff_ffff, 32'h0000_0101},
    '{16'h000c, 8'h00, 32'hffff_ffff, 32'h0000_0201},
    '{16'h0010, 8'h00, 32'hffff_ffff, 32'h0000_0401},
    '{16'h0020, 8'h00, 32'hffff_ffff, 32'h0000_0401},
    '{16'h0040, 8'h00, 32'hffff_ffff, 32'h0000_0401},
    '{16'h4000, 8'h00, 32'hffff_fffe, 32'h0000_0700},
    '{16'h8000, 8'h00, 32'hffff_fffe, 32'h0000_0600},
    '{16'hc000, 8'h00, 32'hffff_fffe, 32'h0000_0600},
    '{16'h0000, 8'h08, 32'hffff_ffff, 32'h0000_0101},
    '{16'h0000, 8'he1, 32'hffff_ffff, 32'h0000_0000},
    '{16'h0100, 8'h00, 32'hffff_ffff, 32'h0000_0802},
    '{16'h0804, 8'h00, 32'hffff_ffff, 32'h0000_2203},
    '{16'h8080, 8'h00, 32'hffff_fffe, 32'h0000_0e02}};
  gis_rd_t rds [9] = '{
    '{9'h000, 4'h0, 16'h3fff, 32'h0000_0903},
    '{9'h000, 4'h1, 16'h0000, 32'h0000_0903},
    '{9'h001, 4'h2, 16'h0000, 32'h0000_0b03},
    '{9'h000, 4'h4, 16'h0000, 32'h0000_0c03},
    '{9'h001, 4'h4, 16'h0000, 32'h0000_0802},
    '{9'h100, 4'h5, 16'h0000, 32'h0000_0802},
    '{9'h101, 4'h6, 16'h0000, 32'h0000_0000},
    '{9'h024, 4'h1, 16'hc000, 32'h0000_0700},
    '{9'h021, 4'h1, 16'h0000, 32'h0000_0000}};
  gis_global_status uut (.CLK_IN(clk_in), .RST_N_IN(rst_n), .REG_RD_IN(rd), .REG_WR_IN(wr),
    .REG_ADDR_IN(addr), .REG_BE_IN(be), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .RX_DATA_READY_IN({src[7], src[0]}), .RX_TIMEOUT_IN({src[9], src[2]}),
    .LINE_STATUS_IN({3'h0, src[8], 4'h0, 3'h0, src[1], 4'h0} | {8'h00, lx}),
    .TX_SPACE_READY_IN({src[10], src[3]}), .MODEM_DELTA_IN({src[11], src[4]}),
    .XON_XOFF_DET_IN({src[12], src[5]}), .SPECIAL_CHAR_IN({src[13], src[6]}),
    .TIMER_IRQ_IN(src[14]), .MULTIPIN_IRQ_IN(src[15]), .CH_SLEEP_IN(sleep),
    .GLOBAL_STATUS_OUT(status), .WAKE_PENDING_OUT(wake), .CH_RX_READ_OUT(rx_rd),
    .CH_LSR_READ_OUT(lsr_rd), .CH_ISR_READ_OUT(isr_rd), .CH_MSR_READ_OUT(msr_rd),
    .TIMER_CMD_READ_OUT(tmr_rd), .MULTIPIN_LEVEL_READ_OUT(mpin_rd));
  gis_src_model mdl (.clk_in(clk_in), .rst_n_in(mrst_n), .set_in(set), .rx_rd_in(rx_rd),
    .lsr_rd_in(lsr_rd), .isr_rd_in(isr_rd), .msr_rd_in(msr_rd), .tmr_rd_in(tmr_rd),
    .mpin_rd_in(mpin_rd), .src_out(src));
  always #2 clk_in = ~clk_in;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Held through the sampling edge, answer taken one cycle on
  task automatic rd_word(input logic [10:2] a, input logic [3:0] b);
    rd = 1'b1;
    addr = a;
    be = b;
    tick(1);
    rd = 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_in);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    chk("reset status", 32'h0, status);
    #1;
    rst_n = 1'b1;
    mrst_n = 1'b1;
    tick(2);
    chk("status after reset", 32'h0, status);
    foreach (rows[i]) begin
      mrst_n = 1'b0;
      lx = rows[i].lx;
      tick(1);
      mrst_n = 1'b1;
      set = rows[i].set;
      tick(1);
      set = 16'h0000;
      tick(1);
      msk = rows[i].mask;
      chk("row status", rows[i].exp & msk, status & msk);
      chk("row code0", rows[i].exp & 32'h700, status & 32'h700);
      chk("row code1", rows[i].exp & 32'h3800, status & 32'h3800);
    end
    // Sources left by the last row would spoil the clearing expectations
    mrst_n = 1'b0;
    tick(1);
    mrst_n = 1'b1;
    foreach (rds[i]) begin
      set = rds[i].set;
      tick(1);
      set = 16'h0000;
      rd_word(rds[i].a, rds[i].be);
      chk("read valid", 32'h1, {31'h0, rvalid});
      tick(2);
      msk = (rds[i].exp[10:9] == 2'b11) ? 32'hffff_fffe : 32'hffff_ffff;
      chk("cleared status", rds[i].exp & msk, status & msk);
      chk("clr code0", rds[i].exp & 32'h700, status & 32'h700);
      chk("clr code1", rds[i].exp & 32'h3800, status & 32'h3800);
    end
    set = 16'h0400;
    tick(1);
    set = 16'h0000;
    tick(1);
    rd_word(9'h020, 4'hf);
    chk("status read", 32'h0000_1802, rdata);
    rd_word(9'h120, 4'hf);
    chk("mirror read", 32'h0000_1802, rdata);
    wr = 1'b1;
    addr = 9'h020;
    tick(1);
    wr = 1'b0;
    tick(1);
    chk("status after write", 32'h0000_1802, status);
    rd_word(9'h030, 4'hf);
    chk("unmapped read", 32'h0, rdata);
    sleep = 2'b01;
    tick(1);
    sleep = 2'b00;
    tick(2);
    chk("wake one asleep", 32'h0, {31'h0, wake});
    sleep = 2'b11;
    tick(1);
    sleep = 2'b00;
    tick(2);
    chk("wake both asleep", 32'h1, {31'h0, wake});
    chk("wake code", 32'h0000_1802, status);
    rd_word(9'h020, 4'h1);
    chk("wake after read", 32'h0, {31'h0, wake});
    rst_n = 1'b0;
    mrst_n = 1'b0;
    tick(1);
    chk("mid reset status", 32'h0, status);
    rst_n = 1'b1;
    mrst_n = 1'b1;
    tick(2);
    chk("status after mid reset", 32'h0, status);
    chk("wake after mid reset", 32'h0, {31'h0, wake});
    complete_run;
  end
endmodule
`default_nettype wire
